// ===== lar_host.sv
// Behaviour
// [RULE1] Start selects pixel one, holds, then clears
// [RULE2] Next period releases clear, advances pixel
// [RULE3] Output floats after edge n plus one
// [RULE4] New start allowed on edge n plus one
// [RULE5] Start spacing never exceeds 100 ms
// [RULE6] Integration time is read-to-read interval
// [RULE7] Start spacing at least n clock periods
// [RULE8] Clock rate constant during a scan; a full FIFO stretches the array clock period instead
// [RULE9] Power-up flush scan, data discarded
// [RULE10] Array clock parked low when idle
// [RULE11] Flag saturated pixels so interval shrinks
// [RULE12] Sample valid whole period, clock under 5 MHz
// [RULE13] Start drops before the next rising edge
// [RULE14] Array samples start on rising edge
// [RULE15] One sample per period, index k is pixel k
`timescale 1ns/1ps
module lar_host #(
  parameter int unsigned TINT_MAX_CYC = lar_pkg::TINT_MAX_CYC_DEF
) (
  input wire logic clk, // System clock, 20 MHz
  input wire logic resetn, // Async reset, active low
  lar_if.host link, // Pins toward the array
  input wire logic scan_en, // Keep scanning after the flush
  input wire logic [lar_pkg::CNT_W-1:0] int_time, // Wanted start spacing, system clocks
  output logic [lar_pkg::SAMP_W-1:0] samp_data, // Pixel index and sample
  output logic samp_valid, // samp_data holds a sample
  input wire logic samp_ready, // Consumer takes samp_data
  output logic sat_seen, // Sticky: a saturated sample was seen
  input wire logic sat_clr, // Clears sat_seen
  output logic flush_done // Power-up flush scan finished
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_LAUNCH = 3'b010,
    H_RUN = 3'b100
  } lar_hstate_e;

  localparam logic [lar_pkg::CNT_W-1:0] TINT_TOP = lar_pkg::CNT_W'(TINT_MAX_CYC - lar_pkg::ACLK_CYC_INT);
  // Clocks from the relaunch decision to the edge that carries the new start
  localparam logic [lar_pkg::CNT_W-1:0] RELAUNCH_LEAD =
    lar_pkg::CNT_W'(lar_pkg::ACLK_CYC_INT - lar_pkg::DIV_HALF + lar_pkg::DIV_ONE);

  lar_hstate_e state_reg;
  logic [lar_pkg::DIV_W-1:0] div_reg;
  logic [lar_pkg::PTR_W-1:0] edge_reg;
  logic [lar_pkg::CNT_W-1:0] int_cnt_reg;
  logic aclk_reg, start_reg, flush_reg, flush_done_reg, sat_reg;
  logic [lar_pkg::DATA_W-1:0] pix_s1, pix_s2;
  logic oe_s1, oe_s2;
  logic [lar_pkg::CNT_W-1:0] target;
  logic push, fifo_ready, stall, wrap, fall, due, due_ahead, relaunch;
  logic [lar_pkg::SAMP_W-1:0] push_data;

  // Keep the spacing inside the documented window
  always_comb
  begin
    target = int_time;
    if (target < lar_pkg::TINT_MIN_CYC)
    begin
      target = lar_pkg::TINT_MIN_CYC; // [RULE7]
    end
    else if (target > TINT_TOP)
    begin
      target = TINT_TOP; // [RULE5]
    end
  end

  // Array output comes back through two flops
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pix_s1 <= '0;
      pix_s2 <= '0;
      oe_s1 <= 1'b0;
      oe_s2 <= 1'b0;
    end
    else
    begin
      pix_s1 <= link.pix_data;
      pix_s2 <= pix_s1;
      oe_s1 <= link.pix_oe;
      oe_s2 <= oe_s1;
    end
  end

  // Sample at the very end of each period, after the array has settled
  assign push = state_reg == H_RUN && div_reg == lar_pkg::DIV_LAST && !flush_reg
    && edge_reg != lar_pkg::N_PIX_P1 && oe_s2; // [RULE9] [RULE12] [RULE15]
  assign push_data = {lar_pkg::PTR_W'(edge_reg - lar_pkg::PTR_ONE), pix_s2}; // [RULE15]
  // A full FIFO delays the next edge; this costs integration evenness
  assign stall = push && !fifo_ready;
  assign wrap = state_reg != H_IDLE && div_reg == lar_pkg::DIV_LAST && !stall;
  assign fall = state_reg != H_IDLE && div_reg == lar_pkg::DIV_FALL;
  assign due = scan_en && flush_done_reg && int_cnt_reg >= target;
  // Judged against the spacing at the coming edge, else back-to-back scans never fit
  assign due_ahead = scan_en && flush_done_reg
    && lar_pkg::CNT_W'(int_cnt_reg + RELAUNCH_LEAD) >= target; // [RULE4] [RULE7]
  assign relaunch = state_reg == H_RUN && edge_reg == lar_pkg::N_PIX && div_reg == lar_pkg::DIV_HALF && due_ahead;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= H_IDLE;
      div_reg <= lar_pkg::DIV_HALF;
      edge_reg <= lar_pkg::PTR_ZERO;
    end
    else
    begin
      unique case (state_reg)
        H_IDLE:
        begin
          div_reg <= lar_pkg::DIV_HALF;
          if (flush_reg || due)
          begin
            state_reg <= H_LAUNCH; // [RULE9]
          end
        end
        H_LAUNCH:
        begin
          div_reg <= wrap ? lar_pkg::DIV_ZERO : lar_pkg::DIV_W'(div_reg + lar_pkg::DIV_ONE);
          if (wrap)
          begin
            state_reg <= H_RUN;
            edge_reg <= lar_pkg::PTR_ONE;
          end
        end
        H_RUN:
        begin
          if (!stall)
          begin
            div_reg <= wrap ? lar_pkg::DIV_ZERO : lar_pkg::DIV_W'(div_reg + lar_pkg::DIV_ONE); // [RULE8]
          end
          if (wrap)
          begin
            edge_reg <= start_reg ? lar_pkg::PTR_ONE : lar_pkg::PTR_W'(edge_reg + lar_pkg::PTR_ONE); // [RULE4]
          end
          if (fall && edge_reg == lar_pkg::N_PIX_P1)
          begin
            state_reg <= H_IDLE; // [RULE10]
          end
        end
      endcase
    end
  end

  // Array clock: rises on wrap, falls mid-period, low whenever idle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aclk_reg <= 1'b0;
    end
    else if (wrap)
    begin
      aclk_reg <= 1'b1;
    end
    else if (fall)
    begin
      aclk_reg <= 1'b0; // [RULE10]
    end
  end

  // Start rises in a low phase and drops at the following fall
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      start_reg <= 1'b0;
    end
    else if (state_reg == H_IDLE && (flush_reg || due))
    begin
      start_reg <= 1'b1;
    end
    else if (relaunch)
    begin
      start_reg <= 1'b1; // [RULE4]
    end
    else if (fall && aclk_reg)
    begin
      start_reg <= 1'b0; // [RULE13]
    end
  end

  // Spacing counter restarts on every edge that carries a start
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      int_cnt_reg <= lar_pkg::CNT_ZERO;
    end
    else if (wrap && start_reg)
    begin
      int_cnt_reg <= lar_pkg::CNT_ZERO; // [RULE5] [RULE7]
    end
    else if (int_cnt_reg != TINT_TOP)
    begin
      int_cnt_reg <= lar_pkg::CNT_W'(int_cnt_reg + lar_pkg::CNT_ONE);
    end
  end

  // First scan after reset only clears stale charge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flush_reg <= 1'b1;
      flush_done_reg <= 1'b0;
    end
    else if (flush_reg && state_reg == H_RUN && wrap && edge_reg == lar_pkg::N_PIX)
    begin
      flush_reg <= 1'b0; // [RULE9]
      flush_done_reg <= 1'b1;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sat_reg <= 1'b0;
    end
    else if (push && fifo_ready && pix_s2 == lar_pkg::PIX_SAT)
    begin
      sat_reg <= 1'b1; // [RULE11]
    end
    else if (sat_clr)
    begin
      sat_reg <= 1'b0;
    end
  end

  lar_fifo #(
    .W(lar_pkg::SAMP_W),
    .D(lar_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_data),
    .out_valid(samp_valid),
    .out_ready(samp_ready),
    .out_data(samp_data)
  );

  assign link.aclk_pin = aclk_reg;
  assign link.start_pin = start_reg;
  assign sat_seen = sat_reg;
  assign flush_done = flush_done_reg;
endmodule

// ===== lar_pkg.sv
package lar_pkg;
  // Array geometry and sample layout
  localparam int N_PIX_INT = 640;
  localparam int PTR_W = 10;
  localparam logic [PTR_W-1:0] N_PIX = PTR_W'(N_PIX_INT);
  localparam logic [PTR_W-1:0] N_PIX_P1 = PTR_W'(N_PIX_INT + 1);
  localparam logic [PTR_W-1:0] PTR_ONE = 10'h001;
  localparam logic [PTR_W-1:0] PTR_ZERO = 10'h000;
  localparam int DATA_W = 8;
  localparam int SAMP_W = PTR_W + DATA_W;
  localparam logic [DATA_W-1:0] PIX_SAT = 8'hFF;
  localparam int FIFO_DEPTH = 16;

  // System clock and array clock timing
  localparam int CLK_NS = 50;
  localparam int ACLK_NS = 400;
  localparam int ACLK_MIN_NS = 200;
  localparam int ACLK_CYC_INT = ACLK_NS / CLK_NS;
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(ACLK_CYC_INT - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(ACLK_CYC_INT / 2);
  localparam logic [DIV_W-1:0] DIV_FALL = DIV_W'(ACLK_CYC_INT / 2 - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = 3'h0;
  localparam logic [DIV_W-1:0] DIV_ONE = 3'h1;

  // Integration interval limits, counted in system clocks
  localparam int CNT_W = 21;
  localparam int TINT_MAX_MS = 100;
  localparam int TINT_MAX_CYC_DEF = TINT_MAX_MS * 1000000 / CLK_NS;
  localparam logic [CNT_W-1:0] TINT_MIN_CYC = CNT_W'(N_PIX_INT * ACLK_CYC_INT);
  localparam logic [CNT_W-1:0] CNT_ONE = 21'h000001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 21'h000000;

  // Pixel charge model inside the array
  localparam int TS_W = 24;
  localparam int PROD_W = DATA_W + TS_W;
  localparam int CHARGE_SHIFT = 14;
  localparam logic [TS_W-1:0] TS_ONE = 24'h000001;
endpackage

// ===== lar_if.sv
`timescale 1ns/1ps
interface lar_if;
  logic start_pin; // Start-integration pulse, host to array
  logic aclk_pin; // Array clock, host to array
  logic [lar_pkg::DATA_W-1:0] pix_data; // Pixel sample from the array
  logic pix_oe; // Array drives pix_data; low means high impedance

  modport dev (
    input start_pin,
    input aclk_pin,
    output pix_data,
    output pix_oe
  );

  modport host (
    output start_pin,
    output aclk_pin,
    input pix_data,
    input pix_oe
  );
endinterface

// ===== lar_fifo.sv
`timescale 1ns/1ps
module lar_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic in_valid, // Write request
  output logic in_ready, // Room for a word
  input wire logic [W-1:0] in_data, // Write data
  output logic out_valid, // Head word valid
  input wire logic out_ready, // Consumer takes head
  output logic [W-1:0] out_data // Head word
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic out_valid_reg;
  logic [W-1:0] out_data_reg;
  logic push;
  logic load;

  assign in_ready = (count_reg != CNT_FULL);
  assign push = in_valid && in_ready;
  // Output stage refills as soon as it empties, so out_data is a flop
  assign load = (count_reg != '0) && (!out_valid_reg || out_ready);
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
      end
      if (load)
      begin
        rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
      end
      count_reg <= CW'(count_reg + CW'(push) - CW'(load));
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end
    else if (load)
    begin
      out_valid_reg <= 1'b1;
      out_data_reg <= mem[rd_ptr_reg];
    end
    else if (out_ready)
    begin
      out_valid_reg <= 1'b0;
    end
  end
endmodule

// ===== lar_dev.sv
`timescale 1ns/1ps
module lar_dev (
  input wire logic clk, // System clock, 20 MHz
  input wire logic resetn, // Async reset, active low
  lar_if.dev link, // Pins toward the controller
  input wire logic [lar_pkg::DATA_W-1:0] light_level, // Irradiance on the array
  output logic scan_active // Array is presenting pixels
);
  typedef enum logic [1:0] {
    D_IDLE = 2'b01,
    D_SCAN = 2'b10
  } lar_dstate_e;

  lar_dstate_e state_reg;
  logic aclk_s1, aclk_s2, aclk_s3;
  logic start_s1, start_s2;
  logic [lar_pkg::PTR_W-1:0] ptr_reg;
  logic [lar_pkg::TS_W-1:0] now_reg;
  logic [lar_pkg::TS_W-1:0] stamp_mem [lar_pkg::N_PIX_INT];
  logic [lar_pkg::DATA_W-1:0] data_reg;
  logic oe_reg;
  logic rise, launch, present, finish;
  logic [lar_pkg::PTR_W-1:0] idx;
  logic [lar_pkg::TS_W-1:0] elapsed;
  logic [lar_pkg::PROD_W-1:0] charge;
  logic [lar_pkg::DATA_W-1:0] level;

  // Pins come from the controller's clock domain
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aclk_s1 <= 1'b0;
      aclk_s2 <= 1'b0;
      aclk_s3 <= 1'b0;
      start_s1 <= 1'b0;
      start_s2 <= 1'b0;
    end
    else
    begin
      aclk_s1 <= link.aclk_pin;
      aclk_s2 <= aclk_s1;
      aclk_s3 <= aclk_s2;
      start_s1 <= link.start_pin;
      start_s2 <= start_s1;
    end
  end

  assign rise = aclk_s2 && !aclk_s3; // [RULE14]
  // Start counts only when idle or at the edge after the last pixel
  assign launch = rise && start_s2 && (state_reg == D_IDLE || ptr_reg == lar_pkg::N_PIX); // [RULE1] [RULE4]
  assign present = launch || (rise && state_reg == D_SCAN && ptr_reg != lar_pkg::N_PIX); // [RULE2]
  assign finish = rise && !launch && state_reg == D_SCAN && ptr_reg == lar_pkg::N_PIX; // [RULE3]
  assign idx = launch ? lar_pkg::PTR_ZERO : ptr_reg;

  // Charge grows with time since this pixel was last cleared
  assign elapsed = lar_pkg::TS_W'(now_reg - stamp_mem[idx]); // [RULE6]
  // Widen both factors first so the product cannot wrap
  assign charge = (lar_pkg::PROD_W'(light_level) * lar_pkg::PROD_W'(elapsed)) >> lar_pkg::CHARGE_SHIFT;
  assign level = (charge > lar_pkg::PROD_W'(lar_pkg::PIX_SAT)) ? lar_pkg::PIX_SAT : charge[lar_pkg::DATA_W-1:0];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      now_reg <= '0;
    end
    else
    begin
      now_reg <= lar_pkg::TS_W'(now_reg + lar_pkg::TS_ONE);
    end
  end

  // No reset: stale charge after power-up is real and must be flushed
  always_ff @(posedge clk)
  begin
    if (present)
    begin
      stamp_mem[idx] <= now_reg; // [RULE1] [RULE6]
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= D_IDLE;
      ptr_reg <= lar_pkg::PTR_ZERO;
    end
    else if (launch)
    begin
      state_reg <= D_SCAN;
      ptr_reg <= lar_pkg::PTR_ONE; // [RULE1]
    end
    else if (present)
    begin
      ptr_reg <= lar_pkg::PTR_W'(ptr_reg + lar_pkg::PTR_ONE); // [RULE2] [RULE14]
    end
    else if (finish)
    begin
      state_reg <= D_IDLE;
    end
  end

  // Held sample stands for the whole array clock period
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      data_reg <= '0;
      oe_reg <= 1'b0;
    end
    else if (present)
    begin
      data_reg <= level; // [RULE12]
      oe_reg <= 1'b1;
    end
    else if (finish)
    begin
      oe_reg <= 1'b0; // [RULE3]
    end
  end

  assign link.pix_data = data_reg;
  assign link.pix_oe = oe_reg;
  assign scan_active = oe_reg;
endmodule

// ===== lar_properties.sv
`timescale 1ns/1ps
module lar_checker #(
  parameter int TINT_MAX_CYC = 6000
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic start_pin, // Start pulse
  input wire logic aclk_pin, // Array clock
  input wire logic [lar_pkg::DATA_W-1:0] pix_data, // Pixel sample
  input wire logic pix_oe // Array drives pix_data
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic aclk_q;
  logic rise;
  logic launch;
  logic [9:0] edge_reg;
  logic [2:0] rise_reg;
  logic [21:0] gap_reg;
  assign rise = aclk_pin && !aclk_q;
  // Launch from idle, after the last pixel, or on the relaunch edge
  assign launch = rise && start_pin && (edge_reg == 10'h000 || edge_reg >= 10'h280);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aclk_q <= 1'b0;
      edge_reg <= 10'h000;
      rise_reg <= 3'h7;
      gap_reg <= 22'h000000;
    end
    else
    begin
      aclk_q <= aclk_pin;
      if (launch)
        edge_reg <= 10'h001;
      else if (rise && edge_reg != 10'h000 && edge_reg < 10'h281)
        edge_reg <= edge_reg + 10'h001;
      if (rise)
        rise_reg <= 3'h0;
      else if (rise_reg != 3'h7)
        rise_reg <= rise_reg + 3'h1;
      if (launch)
        gap_reg <= 22'h000001;
      else if (gap_reg != 22'h000000 && gap_reg != 22'h3FFFFF)
        gap_reg <= gap_reg + 22'h000001;
    end
  end
  property p_launch;
    rise && start_pin && !pix_oe |-> ##[2:4] pix_oe;
  endproperty
  a_launch: assert property (p_launch) else $error("output not driven after launch");
  property p_stand;
    pix_oe && $past(pix_oe) && $changed(pix_data) |-> rise_reg inside {[3'h1:3'h4]};
  endproperty
  a_stand: assert property (p_stand) else $error("pixel data changed mid period");
  property p_float;
    rise && edge_reg == 10'h280 && !start_pin |-> ##[2:4] !pix_oe;
  endproperty
  a_float: assert property (p_float) else $error("output not floated after last edge");
  property p_relaunch;
    rise && edge_reg == 10'h280 && start_pin |-> ##1 pix_oe [*5];
  endproperty
  a_relaunch: assert property (p_relaunch) else $error("relaunch dropped output");
  property p_oe_span;
    $fell(pix_oe) |-> edge_reg == 10'h281;
  endproperty
  a_oe_span: assert property (p_oe_span) else $error("output floated early");
  property p_start_drop;
    rise && start_pin |-> ##[1:5] !start_pin;
  endproperty
  a_start_drop: assert property (p_start_drop) else $error("start held too long");
  property p_park;
    rise |-> start_pin || (edge_reg != 10'h000 && edge_reg < 10'h281);
  endproperty
  a_park: assert property (p_park) else $error("array clock ran while idle");
  property p_high;
    rise |-> aclk_pin [*4] ##1 !aclk_pin;
  endproperty
  a_high: assert property (p_high) else $error("array clock high phase wrong");
  property p_low;
    $fell(aclk_pin) |-> !aclk_pin [*3];
  endproperty
  a_low: assert property (p_low) else $error("array clock low phase short");
  property p_gap;
    launch && gap_reg != 22'h000000 |-> gap_reg >= 22'h001400 && gap_reg <= TINT_MAX_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("start spacing out of range");
  c_launch: cover property (rise && start_pin && !pix_oe);
  c_relaunch: cover property (rise && edge_reg == 10'h280 && start_pin);
  c_float: cover property ($fell(pix_oe));
endmodule

// ===== linear_array_readout_sequencer_bench.sv
`timescale 1ns/1ps
module linear_array_readout_sequencer_bench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic scan_en = 1'b0;
  logic samp_ready = 1'b0;
  logic sat_clr = 1'b0;
  logic [lar_pkg::CNT_W-1:0] int_time = 21'h001400;
  logic [lar_pkg::DATA_W-1:0] light = 8'h40;
  logic [lar_pkg::SAMP_W-1:0] samp_data;
  logic samp_valid, sat_seen, flush_done, act_a, act_b;
  int errors = 0;
  int compares = 0;
  lar_if link_a ();
  lar_if link_b ();
  always #25 clk = ~clk;
  lar_dev u_lar_dev (.clk(clk), .resetn(resetn), .link(link_a), .light_level(light), .scan_active(act_a));
  lar_host #(.TINT_MAX_CYC(6000)) u_lar_host (.clk(clk), .resetn(resetn), .link(link_a), .scan_en(scan_en),
    .int_time(int_time), .samp_data(samp_data), .samp_valid(samp_valid), .samp_ready(samp_ready),
    .sat_seen(sat_seen), .sat_clr(sat_clr), .flush_done(flush_done));
  lar_checker #(.TINT_MAX_CYC(6000)) u_lar_checker (.clk(clk), .resetn(resetn), .start_pin(link_a.start_pin),
    .aclk_pin(link_a.aclk_pin), .pix_data(link_a.pix_data), .pix_oe(link_a.pix_oe));
  // Second array driven by the bench, so pin misuse can be provoked
  lar_dev u_lar_dev_b (.clk(clk), .resetn(resetn), .link(link_b), .light_level(light), .scan_active(act_b));

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Charge model rounding may differ by one count
  task automatic chk_near(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp && got !== exp + 8'h01 && got !== exp - 8'h01)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic pulse(input logic st, output logic oe, output logic [7:0] d);
    link_b.aclk_pin = 1'b1;
    link_b.start_pin = st;
    repeat (4) @(negedge clk);
    link_b.aclk_pin = 1'b0;
    link_b.start_pin = 1'b0;
    repeat (4) @(negedge clk);
    oe = link_b.pix_oe;
    d = link_b.pix_data;
  endtask

  task automatic b_scan(input int e0, input int t, input logic bad, input logic rl);
    logic oe;
    logic [7:0] d;
    for (int e = e0; e <= 641; e++)
    begin
      pulse(e == 1 || (bad && e == 300) || (rl && e == 641), oe, d);
      chk({17'h00000, oe}, {17'h00000, e < 641 || rl});
      chk({17'h00000, act_b}, {17'h00000, e < 641 || rl});
      if (t > 0 && e > 1 && e < 641)
        chk_near(d, 8'((64 * t) >> 14));
    end
  endtask

  task automatic get(output logic [17:0] w);
    int n = 0;
    while (samp_valid !== 1'b1 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    w = samp_data;
    samp_ready = 1'b1;
    @(negedge clk);
    samp_ready = 1'b0;
  endtask

  task automatic seq_a();
    logic [17:0] w;
    int n = 0;
    while (flush_done !== 1'b1 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    chk({17'h00000, flush_done}, 18'h00001);
    for (int s = 0; s < 3; s++)
    begin
      // Consumer stalls so the buffer fills and the array clock waits
      if (s == 0)
        repeat (400) @(negedge clk);
      if (s == 0)
        chk({17'h00000, link_a.aclk_pin}, 18'h00000);
      if (s == 0)
        chk({17'h00000, act_a}, 18'h00001);
      for (int k = 0; k < 640; k++)
      begin
        get(w);
        chk({8'h00, w[17:8]}, {8'h00, 10'(k)});
        if (s == 2)
          chk_near(w[7:0], 8'h14);
      end
    end
    chk({17'h00000, sat_seen}, 18'h00000);
  endtask

  task automatic seq_b();
    b_scan(1, 0, 1'b0, 1'b1);
    b_scan(2, 5120, 1'b0, 1'b0);
    repeat (10872) @(negedge clk);
    b_scan(1, 16000, 1'b1, 1'b0);
  endtask

  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    link_b.start_pin = 1'b0;
    link_b.aclk_pin = 1'b0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    scan_en = 1'b1;
    sat_clr = 1'b1;
    @(negedge clk);
    sat_clr = 1'b0;
    fork
      seq_a();
      seq_b();
    join
    close_out();
  end

  initial
  begin
    #3000000;
    errors++;
    close_out();
  end
endmodule
